// ===== verilog/crs_register_set.sv
`timescale 1ns/1ps
`default_nettype none
module crs_register_set (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic wr_en_in,
   input wire logic [2:0] wr_sel_in,
   input wire logic [7:0] wr_data_in,
   input wire logic prefix_in,
   input wire logic [2:0] rd_sel_in,
   output logic [7:0] rd_data_out,
   input wire logic [2:0] cls_in,
   input wire logic [7:0] result_in,
   input wire logic carry_in,
   input wire logic half_carry_in,
   input wire logic carry_wr_en_in,
   input wire logic carry_wr_val_in,
   input wire logic prio_wr_en_in,
   input wire logic [1:0] prio_wr_val_in,
   input wire logic irq_restore_in,
   input wire logic [7:0] irq_acc_in,
   input wire logic [7:0] irq_idx1_in,
   input wire logic [7:0] irq_flags_in,
   input wire logic ip_load_in,
   input wire logic [15:0] ip_load_val_in,
   input wire logic ip_step_in,
   input wire logic [2:0] br_cond_in,
   output logic br_take_out,
   output logic [7:0] acc_out,
   output logic [7:0] idx1_out,
   output logic [7:0] idx2_out,
   output logic [15:0] next_instruction_pointer_out,
   output logic [7:0] condition_flags_out,
   output logic [1:0] prio_level_out,
   output logic irq_disabled_out
);
   logic [7:0] acc;
   logic [7:0] idx1;
   logic [7:0] idx2;
   logic [7:0] instr_pointer_low_byte;
   logic [7:0] instr_pointer_high_byte;
   logic [7:0] condition_flags;
   logic [7:0] next_flags;

   // The prefix turns a first-index selection into a second-index one.
   function automatic logic [2:0] crs_remap(input logic [2:0] sel, input logic pre);
      if (pre && sel == 3'(crs_pkg::CRS_SEL_IDX1)) begin
         crs_remap = 3'(crs_pkg::CRS_SEL_IDX2);
      end else begin
         crs_remap = sel;
      end
   endfunction

   wire [2:0] wsel = crs_remap(wr_sel_in, prefix_in);
   wire [2:0] rsel = crs_remap(rd_sel_in, prefix_in);
   wire flags_wr = wr_en_in && wsel == 3'(crs_pkg::CRS_SEL_FLAGS);
   wire [15:0] ip_now = {instr_pointer_high_byte, instr_pointer_low_byte};
   wire [15:0] ip_inc = ip_now + 16'h0001;
   wire res_cls = cls_in != 3'(crs_pkg::CRS_CLS_NONE);
   wire carry_cls = cls_in == 3'(crs_pkg::CRS_CLS_ADD) ||
                    cls_in == 3'(crs_pkg::CRS_CLS_ARITH) ||
                    cls_in == 3'(crs_pkg::CRS_CLS_SHIFT);
   wire flag_half = condition_flags[crs_pkg::FLAG_HALF];
   wire flag_neg = condition_flags[crs_pkg::FLAG_NEG];
   wire flag_zero = condition_flags[crs_pkg::FLAG_ZERO];
   wire flag_carry = condition_flags[crs_pkg::FLAG_CARRY];

   always_comb begin
      next_flags = condition_flags;
      if (irq_restore_in) begin
         next_flags = irq_flags_in;
      end else if (flags_wr) begin
         next_flags = wr_data_in;
      end else begin
         if (res_cls) begin
            next_flags[crs_pkg::FLAG_NEG] = result_in[7];
            next_flags[crs_pkg::FLAG_ZERO] = result_in == 8'h00;
         end
         if (cls_in == 3'(crs_pkg::CRS_CLS_ADD)) begin
            next_flags[crs_pkg::FLAG_HALF] = half_carry_in;
         end
         if (carry_wr_en_in) begin
            next_flags[crs_pkg::FLAG_CARRY] = carry_wr_val_in;
         end else if (carry_cls) begin
            next_flags[crs_pkg::FLAG_CARRY] = carry_in;
         end
         if (prio_wr_en_in) begin
            next_flags[crs_pkg::FLAG_PRIO_UPPER] = prio_wr_val_in[1];
            next_flags[crs_pkg::FLAG_PRIO_LOWER] = prio_wr_val_in[0];
         end
      end
      next_flags = next_flags | crs_pkg::FLAGS_FIXED_ONES;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         condition_flags <= crs_pkg::FLAGS_RESET;
      end else begin
         condition_flags <= next_flags;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         acc <= crs_pkg::REG_RESET;
         idx1 <= crs_pkg::REG_RESET;
         idx2 <= crs_pkg::REG_RESET;
      end else if (irq_restore_in) begin
         // Of the data registers, only the accumulator and first index come back from the stack.
         acc <= irq_acc_in;
         idx1 <= irq_idx1_in;
      end else if (wr_en_in) begin
         if (wsel == 3'(crs_pkg::CRS_SEL_ACC)) begin
            acc <= wr_data_in;
         end
         if (wsel == 3'(crs_pkg::CRS_SEL_IDX1)) begin
            idx1 <= wr_data_in;
         end
         if (wsel == 3'(crs_pkg::CRS_SEL_IDX2)) begin
            idx2 <= wr_data_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         instr_pointer_low_byte <= crs_pkg::IP_RESET[7:0];
         instr_pointer_high_byte <= crs_pkg::IP_RESET[15:8];
      end else if (ip_load_in) begin
         instr_pointer_low_byte <= ip_load_val_in[7:0];
         instr_pointer_high_byte <= ip_load_val_in[15:8];
      end else if (wr_en_in && wsel == 3'(crs_pkg::CRS_SEL_IP_LOW)) begin
         instr_pointer_low_byte <= wr_data_in;
      end else if (wr_en_in && wsel == 3'(crs_pkg::CRS_SEL_IP_HIGH)) begin
         instr_pointer_high_byte <= wr_data_in;
      end else if (ip_step_in) begin
         instr_pointer_low_byte <= ip_inc[7:0];
         instr_pointer_high_byte <= ip_inc[15:8];
      end
   end

   // Register reads go by selector only; no address path exists.
   always_comb begin
      case (rsel)
         3'(crs_pkg::CRS_SEL_ACC): rd_data_out = acc;
         3'(crs_pkg::CRS_SEL_IDX1): rd_data_out = idx1;
         3'(crs_pkg::CRS_SEL_IDX2): rd_data_out = idx2;
         3'(crs_pkg::CRS_SEL_IP_LOW): rd_data_out = instr_pointer_low_byte;
         3'(crs_pkg::CRS_SEL_IP_HIGH): rd_data_out = instr_pointer_high_byte;
         3'(crs_pkg::CRS_SEL_FLAGS): rd_data_out = condition_flags;
         default: rd_data_out = 8'h00;
      endcase
   end

   always_comb begin
      case (br_cond_in)
         3'(crs_pkg::CRS_BR_HALF_SET): br_take_out = flag_half;
         3'(crs_pkg::CRS_BR_HALF_CLR): br_take_out = !flag_half;
         3'(crs_pkg::CRS_BR_MINUS): br_take_out = flag_neg;
         3'(crs_pkg::CRS_BR_PLUS): br_take_out = !flag_neg;
         3'(crs_pkg::CRS_BR_EQUAL): br_take_out = flag_zero;
         3'(crs_pkg::CRS_BR_NOT_EQUAL): br_take_out = !flag_zero;
         default: br_take_out = 1'b0;
      endcase
   end

   wire [1:0] prio_bits = {condition_flags[crs_pkg::FLAG_PRIO_UPPER],
                           condition_flags[crs_pkg::FLAG_PRIO_LOWER]};
   // Level mapping: 10 -> 0, 01 -> 1, 00 -> 2, 11 -> 3.
   assign prio_level_out = {prio_bits[1] ~^ prio_bits[0], prio_bits[0]};
   assign irq_disabled_out = &prio_bits;
   assign acc_out = acc;
   assign idx1_out = idx1;
   assign idx2_out = idx2;
   assign next_instruction_pointer_out = ip_now;
   assign condition_flags_out = condition_flags;

   a_flags_fixed_ones: assert property (@(posedge clk_in) disable iff (srst_in)
      condition_flags[7:6] == 2'b11) else $error("fixed flag bits not one");
   a_reset_flags: assert property (@(posedge clk_in)
      srst_in |=> condition_flags == crs_pkg::FLAGS_RESET) else $error("bad flags reset");
   a_idx2_irq_hold: assert property (@(posedge clk_in) disable iff (srst_in)
      irq_restore_in |=> $stable(idx2)) else $error("second index changed by restore");
   a_half_carry_add: assert property (@(posedge clk_in) disable iff (srst_in)
      (cls_in == 3'(crs_pkg::CRS_CLS_ADD) && !irq_restore_in && !flags_wr)
      |=> flag_half == $past(half_carry_in)) else $error("half carry wrong");
   a_neg_zero_res: assert property (@(posedge clk_in) disable iff (srst_in)
      (res_cls && !irq_restore_in && !flags_wr) |=>
      flag_neg == $past(result_in[7]) &&
      flag_zero == ($past(result_in) == 8'h00)) else $error("n/z wrong");
   a_flags_unchanged: assert property (@(posedge clk_in) disable iff (srst_in)
      (!res_cls && !irq_restore_in && !flags_wr && !carry_wr_en_in && !prio_wr_en_in)
      |=> $stable(condition_flags)) else $error("flags changed unexpectedly");
   a_branch_zero: assert property (@(posedge clk_in) disable iff (srst_in)
      br_cond_in == 3'(crs_pkg::CRS_BR_EQUAL) |-> br_take_out == flag_zero)
      else $error("equal branch wrong");
   a_prefix_idx2: assert property (@(posedge clk_in) disable iff (srst_in)
      (wr_en_in && prefix_in && wr_sel_in == 3'(crs_pkg::CRS_SEL_IDX1) && !irq_restore_in)
      |=> idx2 == $past(wr_data_in) && $stable(idx1)) else $error("prefix not honoured");
   a_carry_force: assert property (@(posedge clk_in) disable iff (srst_in)
      (carry_wr_en_in && !irq_restore_in && !flags_wr) |=>
      flag_carry == $past(carry_wr_val_in)) else $error("carry force wrong");
   // Level three is the only level that blocks interrupts.
   a_prio_disable: assert property (@(posedge clk_in) disable iff (srst_in)
      irq_disabled_out == (prio_level_out == 2'b11)) else $error("level and disable disagree");
endmodule
`default_nettype wire

// ===== verilog/crs_pkg.sv
`default_nettype none
package crs_pkg;
   // Bit positions inside the condition flags register.
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_ZERO = 1;
   localparam int FLAG_NEG = 2;
   localparam int FLAG_PRIO_LOWER = 3;
   localparam int FLAG_HALF = 4;
   localparam int FLAG_PRIO_UPPER = 5;
   // Undefined reset bits are given zero here.
   localparam logic [7:0] FLAGS_RESET = 8'he8;
   localparam logic [7:0] FLAGS_FIXED_ONES = 8'hc0;
   localparam logic [15:0] IP_RESET = 16'h0000;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Register selectors for dedicated load/store instructions.
   typedef enum logic [2:0] {
      CRS_SEL_ACC,
      CRS_SEL_IDX1,
      CRS_SEL_IDX2,
      CRS_SEL_IP_LOW,
      CRS_SEL_IP_HIGH,
      CRS_SEL_FLAGS
   } crs_sel_e;

   // Flag update class of the executing instruction.
   typedef enum logic [2:0] {
      CRS_CLS_NONE,
      CRS_CLS_ADD,
      CRS_CLS_ARITH,
      CRS_CLS_LOGIC,
      CRS_CLS_SHIFT
   } crs_cls_e;

   // Branch conditions.
   typedef enum logic [2:0] {
      CRS_BR_HALF_SET,
      CRS_BR_HALF_CLR,
      CRS_BR_MINUS,
      CRS_BR_PLUS,
      CRS_BR_EQUAL,
      CRS_BR_NOT_EQUAL
   } crs_br_e;
endpackage
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in, srst_in, wr_en_in, prefix_in, irq_restore_in, ip_load_in, ip_step_in;
   logic carry_in, half_carry_in, carry_wr_en_in, carry_wr_val_in, prio_wr_en_in;
   logic br_take_out, irq_disabled_out;
   logic [1:0] prio_wr_val_in, prio_level_out;
   logic [2:0] wr_sel_in, rd_sel_in, cls_in, br_cond_in;
   logic [7:0] wr_data_in, result_in, irq_acc_in, irq_idx1_in, irq_flags_in, rd_data_out;
   logic [7:0] acc_out, idx1_out, idx2_out, condition_flags_out;
   logic [15:0] ip_load_val_in, next_instruction_pointer_out;
   int err_total = 0;
   int samples_checked = 0;
   crs_register_set dut (.clk_in(clk_in), .srst_in(srst_in), .wr_en_in(wr_en_in),
      .wr_sel_in(wr_sel_in), .wr_data_in(wr_data_in), .prefix_in(prefix_in),
      .rd_sel_in(rd_sel_in), .rd_data_out(rd_data_out), .cls_in(cls_in),
      .result_in(result_in), .carry_in(carry_in), .half_carry_in(half_carry_in),
      .carry_wr_en_in(carry_wr_en_in), .carry_wr_val_in(carry_wr_val_in),
      .prio_wr_en_in(prio_wr_en_in), .prio_wr_val_in(prio_wr_val_in),
      .irq_restore_in(irq_restore_in), .irq_acc_in(irq_acc_in), .irq_idx1_in(irq_idx1_in),
      .irq_flags_in(irq_flags_in), .ip_load_in(ip_load_in), .ip_load_val_in(ip_load_val_in),
      .ip_step_in(ip_step_in), .br_cond_in(br_cond_in), .br_take_out(br_take_out),
      .acc_out(acc_out), .idx1_out(idx1_out), .idx2_out(idx2_out),
      .next_instruction_pointer_out(next_instruction_pointer_out),
      .condition_flags_out(condition_flags_out), .prio_level_out(prio_level_out),
      .irq_disabled_out(irq_disabled_out));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [7:0] d, input logic pre);
      wr_en_in = 1'b1;
      wr_sel_in = sel;
      wr_data_in = d;
      prefix_in = pre;
      tick();
      wr_en_in = 1'b0;
      prefix_in = 1'b0;
      tick();
   endtask
   task automatic alu(input logic [2:0] cls, input logic [7:0] res, input logic c,
                      input logic h, input logic [7:0] exp);
      cls_in = cls;
      result_in = res;
      carry_in = c;
      half_carry_in = h;
      tick();
      cls_in = crs_pkg::CRS_CLS_NONE;
      tick();
      chk(16'(condition_flags_out), 16'(exp));
   endtask
   // Every branch condition is tried against the flags now held.
   task automatic brs(input logic [7:0] f);
      for (int c = 0; c < 8; c++) begin
         int pos;
         logic want;
         pos = (c < 2) ? crs_pkg::FLAG_HALF : (c < 4) ? crs_pkg::FLAG_NEG : crs_pkg::FLAG_ZERO;
         want = (c < 6) ? f[pos] ^ c[0] : 1'b0;
         br_cond_in = 3'(c);
         tick();
         chk(16'(br_take_out), 16'(want));
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      {srst_in, wr_en_in, prefix_in, irq_restore_in, ip_load_in, ip_step_in} = 6'h20;
      {carry_in, half_carry_in, carry_wr_en_in, carry_wr_val_in, prio_wr_en_in} = 5'h00;
      {prio_wr_val_in, wr_sel_in, rd_sel_in, cls_in, br_cond_in} = 14'h0000;
      {wr_data_in, result_in, irq_acc_in, irq_idx1_in, irq_flags_in} = 40'h00;
      ip_load_val_in = 16'h0000;
      repeat (20) tick();
      srst_in = 1'b0;
      chk(16'(condition_flags_out), 16'(crs_pkg::FLAGS_RESET));
      chk({acc_out, idx1_out}, 16'h0000);
      chk(next_instruction_pointer_out, 16'h0000);
      $display("test reset done");
      alu(crs_pkg::CRS_CLS_ADD, 8'h00, 1'b1, 1'b1, 8'hfb);
      brs(8'hfb);
      alu(crs_pkg::CRS_CLS_ADD, 8'h90, 1'b0, 1'b0, 8'hec);
      brs(8'hec);
      alu(crs_pkg::CRS_CLS_LOGIC, 8'h00, 1'b1, 1'b1, 8'hea);
      alu(crs_pkg::CRS_CLS_ARITH, 8'h80, 1'b1, 1'b1, 8'hed);
      alu(crs_pkg::CRS_CLS_SHIFT, 8'h01, 1'b0, 1'b1, 8'he8);
      alu(crs_pkg::CRS_CLS_NONE, 8'h00, 1'b1, 1'b1, 8'he8);
      carry_wr_en_in = 1'b1;
      carry_wr_val_in = 1'b1;
      alu(crs_pkg::CRS_CLS_ARITH, 8'h01, 1'b0, 1'b0, 8'he9);
      carry_wr_en_in = 1'b0;
      $display("test flags done");
      for (int v = 0; v < 4; v++) begin
         prio_wr_en_in = 1'b1;
         prio_wr_val_in = 2'(v);
         tick();
         prio_wr_en_in = 1'b0;
         tick();
         chk(16'({condition_flags_out[5], condition_flags_out[3]}), 16'(v));
         chk(16'(prio_level_out), 16'(v == 0 ? 2 : v == 1 ? 1 : v == 2 ? 0 : 3));
         chk(16'(irq_disabled_out), 16'(v == 3));
      end
      wr(crs_pkg::CRS_SEL_FLAGS, 8'h00, 1'b0);
      rd_sel_in = crs_pkg::CRS_SEL_FLAGS;
      tick();
      chk(16'(rd_data_out), 16'h00c0);
      $display("test priority done");
      wr(crs_pkg::CRS_SEL_ACC, 8'h55, 1'b0);
      wr(crs_pkg::CRS_SEL_IDX1, 8'ha1, 1'b0);
      wr(crs_pkg::CRS_SEL_IDX2, 8'hb2, 1'b0);
      wr(crs_pkg::CRS_SEL_IDX1, 8'hc3, 1'b1);
      chk({acc_out, idx1_out}, 16'h55a1);
      chk(16'(idx2_out), 16'h00c3);
      rd_sel_in = crs_pkg::CRS_SEL_IDX1;
      tick();
      chk(16'(rd_data_out), 16'h00a1);
      prefix_in = 1'b1;
      tick();
      chk(16'(rd_data_out), 16'h00c3);
      prefix_in = 1'b0;
      rd_sel_in = crs_pkg::CRS_SEL_ACC;
      tick();
      chk(16'(rd_data_out), 16'h0055);
      $display("test registers done");
      wr(crs_pkg::CRS_SEL_IP_LOW, 8'h34, 1'b0);
      wr(crs_pkg::CRS_SEL_IP_HIGH, 8'h12, 1'b0);
      chk(next_instruction_pointer_out, 16'h1234);
      rd_sel_in = crs_pkg::CRS_SEL_IP_LOW;
      tick();
      chk(16'(rd_data_out), 16'h0034);
      {ip_load_in, ip_step_in, ip_load_val_in} = {2'b11, 16'h00ff};
      tick();
      ip_load_in = 1'b0;
      tick();
      ip_step_in = 1'b0;
      chk(next_instruction_pointer_out, 16'h0100);
      rd_sel_in = crs_pkg::CRS_SEL_IP_HIGH;
      tick();
      chk(16'(rd_data_out), 16'h0001);
      $display("test pointer done");
      {irq_restore_in, irq_acc_in, irq_idx1_in, irq_flags_in} = {1'b1, 24'h112208};
      tick();
      irq_restore_in = 1'b0;
      chk({acc_out, idx1_out}, 16'h1122);
      chk({idx2_out, condition_flags_out}, 16'hc3c8);
      $display("test restore done");
      srst_in = 1'b1;
      tick();
      tick();
      srst_in = 1'b0;
      chk(16'(condition_flags_out), 16'(crs_pkg::FLAGS_RESET));
      chk({acc_out, idx2_out}, 16'h0000);
      chk(next_instruction_pointer_out, 16'h0000);
      $display("test mid-run reset done");
      final_report();
   end
endmodule
`default_nettype wire
